// file: pfsel_map.svh
`ifndef PFSEL_MAP_SVH
`define PFSEL_MAP_SVH

// Word offsets on the register bus (byte addresses)
`define PFSEL_OFS_SEL7      8'h00
`define PFSEL_OFS_SEL8      8'h04
`define PFSEL_OFS_SEL9      8'h08
`define PFSEL_OFS_WMASK     8'h0c
`define PFSEL_OFS_STATUS    8'h10
`define PFSEL_OFS_ILLEGAL   8'h14

// Reset values
`define PFSEL_SEL_RESET     32'h0000_0000
`define PFSEL_WMASK_RESET   32'h0000_0000

// Status register fields
`define PFSEL_ST_ARMED_BIT  0
`define PFSEL_ST_REFUSE_BIT 1

// Field widths, function and pin counts
`define PFSEL_W_NARROW      2
`define PFSEL_W_WIDE        3
`define PFSEL_NUM_FUNC      8
`define PFSEL_NUM_PIN       32

// Pin table, pin 31 first: {register, field lsb, wide field, legal codes}
`define PFSEL_PIN_TABLE { \
  {2'd2, 5'd28, 1'b1, 8'h1f}, {2'd2, 5'd25, 1'b1, 8'h1b}, \
  {2'd2, 5'd22, 1'b1, 8'h1b}, {2'd2, 5'd19, 1'b1, 8'h0b}, \
  {2'd2, 5'd17, 1'b0, 8'h0f}, {2'd2, 5'd15, 1'b0, 8'h0f}, \
  {2'd2, 5'd12, 1'b1, 8'h0b}, {2'd2, 5'd9,  1'b1, 8'h0b}, \
  {2'd2, 5'd6,  1'b1, 8'h0b}, {2'd2, 5'd3,  1'b1, 8'h2b}, \
  {2'd2, 5'd0,  1'b1, 8'h0f}, {2'd1, 5'd29, 1'b1, 8'h0f}, \
  {2'd1, 5'd26, 1'b1, 8'h0f}, {2'd1, 5'd23, 1'b1, 8'h4f}, \
  {2'd1, 5'd20, 1'b1, 8'h3f}, {2'd1, 5'd17, 1'b1, 8'h7f}, \
  {2'd1, 5'd15, 1'b0, 8'h0f}, {2'd1, 5'd12, 1'b1, 8'h3f}, \
  {2'd1, 5'd9,  1'b1, 8'h3f}, {2'd1, 5'd6,  1'b1, 8'h3f}, \
  {2'd1, 5'd3,  1'b1, 8'h3f}, {2'd1, 5'd0,  1'b1, 8'h3f}, \
  {2'd0, 5'd27, 1'b1, 8'h3f}, {2'd0, 5'd24, 1'b1, 8'h3f}, \
  {2'd0, 5'd21, 1'b1, 8'h3f}, {2'd0, 5'd18, 1'b1, 8'h3f}, \
  {2'd0, 5'd15, 1'b1, 8'h3f}, {2'd0, 5'd12, 1'b1, 8'h3f}, \
  {2'd0, 5'd9,  1'b1, 8'h3f}, {2'd0, 5'd6,  1'b1, 8'h3f}, \
  {2'd0, 5'd3,  1'b1, 8'h3f}, {2'd0, 5'd0,  1'b1, 8'h3f} }

`endif

// file: pfsel_pkg.sv
package pfsel_pkg;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } pfsel_wb_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } pfsel_wb_rsp_t;

  typedef struct packed {
    logic [1:0] reg_idx;
    logic [4:0] lsb;
    logic       wide;
    logic [7:0] legal;
  } pfsel_pin_t;

  typedef logic [7:0] pfsel_func_vec_t;

endpackage

// file: pfsel_field_mux.sv
`timescale 1ns/10ps
`include "pfsel_map.svh"

module pfsel_field_mux (
  input  wire logic                     clk_sys_in,
  input  wire logic                     rst_b_in,
  input  wire logic [2:0]               code_in,
  input  wire pfsel_pkg::pfsel_func_vec_t legal_in,
  input  wire pfsel_pkg::pfsel_func_vec_t func_out_in,
  input  wire pfsel_pkg::pfsel_func_vec_t func_oe_in,
  input  wire logic                     pin_in_in,
  output logic                          pin_out_out,
  output logic                          pin_oe_out,
  output pfsel_pkg::pfsel_func_vec_t    func_in_out
);

  pfsel_pkg::pfsel_func_vec_t onehot;

  // Reserved or prohibited codes select nothing, so the pin floats
  always_comb begin
    onehot = '0;
    if (legal_in[code_in]) begin // R9
      onehot[code_in] = 1'b1; // R4 R5 R6
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pin_out_out <= 1'b0;
      pin_oe_out  <= 1'b0;
      func_in_out <= '0;
    end else begin
      pin_out_out <= |(onehot & func_out_in); // R4
      pin_oe_out  <= |(onehot & func_oe_in);
      func_in_out <= onehot & {`PFSEL_NUM_FUNC{pin_in_in}};
    end
  end

endmodule // pfsel_field_mux

// file: pfsel_top.sv
// Notes on behaviour
// R1: Each of the three select registers is 32 bits wide and resets to all zeros.
// R2: Every bit of each select register is read/write and reads return the last accepted value.
// R3: A select-register write is accepted only when the write just before it went to the mask.
// R4: Each multiplexed pin is routed to the peripheral signal chosen by its field value.
// R5: Field value zero picks a pin's first function, so every pin starts on it after reset.
// R6: Three-bit fields decode values zero to seven as functions one to eight in order.
// R7: Software never writes a prohibited field value.
// R8: Second-register fields support six choices, codes zero to five, each to its own signal; the sel8 map allows four to seven codes per field.
// R9: A reserved or prohibited stored code connects no signal but still reads back unchanged.
`timescale 1ns/10ps
`include "pfsel_map.svh"

module pfsel_top (
  input  wire logic                       clk_sys_in,
  input  wire logic                       rst_b_in,
  input  wire pfsel_pkg::pfsel_wb_req_t   wb_req_in,
  output pfsel_pkg::pfsel_wb_rsp_t        wb_rsp_out,
  input  wire pfsel_pkg::pfsel_func_vec_t periph_out_in [`PFSEL_NUM_PIN],
  input  wire pfsel_pkg::pfsel_func_vec_t periph_oe_in  [`PFSEL_NUM_PIN],
  output pfsel_pkg::pfsel_func_vec_t      periph_in_out [`PFSEL_NUM_PIN],
  input  wire logic [31:0]                pin_in_in,
  output logic      [31:0]                pin_out_out,
  output logic      [31:0]                pin_oe_out
);

  // Packed so that the table's first entry lands on pin 31, as the map lists it
  localparam pfsel_pkg::pfsel_pin_t [`PFSEL_NUM_PIN-1:0] PIN_TABLE = `PFSEL_PIN_TABLE;

  // Extracts one field code; narrow fields are zero-extended
  function automatic logic [2:0] field_code(
    input logic [31:0] word,
    input logic [4:0]  lsb,
    input logic        wide
  );
    logic [31:0] shifted;
    shifted = word >> lsb;
    if (wide) begin
      field_code = shifted[2:0];
    end else begin
      field_code = {1'b0, shifted[1:0]};
    end
  endfunction

  // Applies byte enables to a stored word
  function automatic logic [31:0] lane_merge(
    input logic [31:0] old_word,
    input logic [31:0] new_word,
    input logic [3:0]  lanes
  );
    logic [31:0] merged;
    merged = old_word;
    for (int b = 0; b < 4; b++) begin
      if (lanes[b]) begin
        merged[8*b +: 8] = new_word[8*b +: 8];
      end
    end
    lane_merge = merged;
  endfunction

  logic [31:0] sel7_r;
  logic [31:0] sel8_r;
  logic [31:0] sel9_r;
  logic [31:0] wmask_r;
  logic        armed_r;
  logic        refused_r;
  logic        ack_r;
  logic [31:0] rdata_r;
  logic [31:0] illegal_map;
  logic [2:0]  code       [`PFSEL_NUM_PIN];

  logic        req;
  logic        wr;
  logic        hit_sel7;
  logic        hit_sel8;
  logic        hit_sel9;
  logic        hit_sel;
  logic        hit_wmask;
  logic        hit_status;
  logic        hit_illegal;
  logic        sel_accept;
  logic        sel_refuse;
  logic        refuse_clr;

  // Bus decode

  // New access only while ack is low, so each request acts once
  assign req         = wb_req_in.cyc & wb_req_in.stb & ~ack_r;
  assign wr          = req & wb_req_in.we;
  assign hit_sel7    = (wb_req_in.adr == `PFSEL_OFS_SEL7);
  assign hit_sel8    = (wb_req_in.adr == `PFSEL_OFS_SEL8);
  assign hit_sel9    = (wb_req_in.adr == `PFSEL_OFS_SEL9);
  assign hit_sel     = hit_sel7 | hit_sel8 | hit_sel9;
  assign hit_wmask   = (wb_req_in.adr == `PFSEL_OFS_WMASK);
  assign hit_status  = (wb_req_in.adr == `PFSEL_OFS_STATUS);
  assign hit_illegal = (wb_req_in.adr == `PFSEL_OFS_ILLEGAL);

  assign sel_accept  = wr & hit_sel & armed_r; // R3
  assign sel_refuse  = wr & hit_sel & ~armed_r;
  assign refuse_clr  = wr & hit_status & wb_req_in.sel[0] &
                       wb_req_in.dat[`PFSEL_ST_REFUSE_BIT];

  // Acknowledge

  // Unmapped addresses also answer, reading zero, so a master never hangs
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req;
    end
  end

  assign wb_rsp_out.ack = ack_r;
  assign wb_rsp_out.dat = rdata_r;

  // Select registers

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sel7_r <= `PFSEL_SEL_RESET; // R1
      sel8_r <= `PFSEL_SEL_RESET; // R1
      sel9_r <= `PFSEL_SEL_RESET; // R1
    end else if (sel_accept) begin
      // Every bit is stored as written, reserved codes included
      if (hit_sel7) begin
        sel7_r <= lane_merge(sel7_r, wb_req_in.dat, wb_req_in.sel); // R2 R9
      end
      if (hit_sel8) begin
        sel8_r <= lane_merge(sel8_r, wb_req_in.dat, wb_req_in.sel); // R2 R8
      end
      if (hit_sel9) begin
        sel9_r <= lane_merge(sel9_r, wb_req_in.dat, wb_req_in.sel); // R2
      end
    end
  end

  // Write mask and unlock

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wmask_r <= `PFSEL_WMASK_RESET;
    end else if (wr & hit_wmask) begin
      wmask_r <= lane_merge(wmask_r, wb_req_in.dat, wb_req_in.sel);
    end
  end

  // Any later write to an address other than the mask spends the unlock; reads leave it
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      armed_r <= 1'b0;
    end else if (wr) begin
      armed_r <= hit_wmask; // R3
    end
  end

  // Sticky flag for a select write that came without unlock; set wins over clear
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      refused_r <= 1'b0;
    end else if (sel_refuse) begin
      refused_r <= 1'b1; // R3
    end else if (refuse_clr) begin
      refused_r <= 1'b0;
    end
  end

  // Read data

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rdata_r <= 32'h0000_0000;
    end else if (req & ~wb_req_in.we) begin
      rdata_r <= 32'h0000_0000;
      if (hit_sel7) begin
        rdata_r <= sel7_r; // R2
      end
      if (hit_sel8) begin
        rdata_r <= sel8_r; // R2
      end
      if (hit_sel9) begin
        rdata_r <= sel9_r; // R2
      end
      if (hit_wmask) begin
        rdata_r <= wmask_r;
      end
      if (hit_status) begin
        rdata_r[`PFSEL_ST_ARMED_BIT]  <= armed_r;
        rdata_r[`PFSEL_ST_REFUSE_BIT] <= refused_r;
      end
      if (hit_illegal) begin
        rdata_r <= illegal_map;
      end
    end
  end

  // Pin routing

  // Outputs are registered, so a new selection reaches the pins one
  // cycle after the accepting edge; this avoids glitchy mux paths
  for (genvar p = 0; p < `PFSEL_NUM_PIN; p++) begin : g_pin
    logic [31:0] word;

    always_comb begin
      unique case (PIN_TABLE[p].reg_idx)
        2'd0:    word = sel7_r;
        2'd1:    word = sel8_r;
        default: word = sel9_r;
      endcase
    end

    assign code[p]        = field_code(word, PIN_TABLE[p].lsb, PIN_TABLE[p].wide); // R6
    assign illegal_map[p] = ~PIN_TABLE[p].legal[code[p]]; // R9

    pfsel_field_mux u_mux (
      .clk_sys_in  (clk_sys_in),
      .rst_b_in    (rst_b_in),
      .code_in     (code[p]),
      .legal_in    (PIN_TABLE[p].legal),
      .func_out_in (periph_out_in[p]),
      .func_oe_in  (periph_oe_in[p]),
      .pin_in_in   (pin_in_in[p]),
      .pin_out_out (pin_out_out[p]),
      .pin_oe_out  (pin_oe_out[p]),
      .func_in_out (periph_in_out[p])
    ); // R4 R5
  end

endmodule // pfsel_top

// file: pfsel_props.sv
`timescale 1ns/10ps

module pfsel_props (
  input wire logic                       clk_sys_in,
  input wire logic                       rst_b_in,
  input wire pfsel_pkg::pfsel_wb_req_t   wb_req_in,
  input wire pfsel_pkg::pfsel_wb_rsp_t   wb_rsp_out,
  input wire pfsel_pkg::pfsel_func_vec_t periph_out_in [32],
  input wire pfsel_pkg::pfsel_func_vec_t periph_oe_in  [32],
  input wire pfsel_pkg::pfsel_func_vec_t periph_in_out [32],
  input wire logic [31:0]                pin_in_in,
  input wire logic [31:0]                pin_out_out,
  input wire logic [31:0]                pin_oe_out
);
  logic [31:0] f1o, f1e, ao, ae, ai;
  logic        take;
  logic        clean_r;

  always_comb begin
    for (int p = 0; p < 32; p++) begin
      f1o[p] = periph_out_in[p][0];
      f1e[p] = periph_oe_in[p][0];
      ao[p]  = |periph_out_in[p];
      ae[p]  = |periph_oe_in[p];
      ai[p]  = |periph_in_out[p];
    end
  end

  assign take = wb_req_in.cyc & wb_req_in.stb & ~wb_rsp_out.ack;

  // Conservative: any select write, even a refused one, ends the reset-state check
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) clean_r <= 1'b1;
    else if (take && wb_req_in.we && wb_req_in.adr < 8'h0c) clean_r <= 1'b0;
  end

  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rst_b_in);

  a_ack_next: assert property (take |=> wb_rsp_out.ack) else $error("ack missing");
  a_ack_pulse: assert property (wb_rsp_out.ack |=> !wb_rsp_out.ack) else $error("ack held");
  a_ack_cause: assert property (wb_rsp_out.ack |-> $past(take)) else $error("stray ack");
  a_dat_hold: assert property (!(take && !wb_req_in.we) |=> $stable(wb_rsp_out.dat))
    else $error("read data moved");
  a_func_first: assert property (clean_r && $past(clean_r) && $past(rst_b_in)
    |-> {pin_out_out, pin_oe_out} == $past({f1o, f1e})) else $error("not first function");
  a_out_source: assert property ((pin_out_out & ~$past(ao)) == 32'h0)
    else $error("pin driven high without source");
  a_oe_source: assert property ((pin_oe_out & ~$past(ae)) == 32'h0)
    else $error("pin enabled without source");
  a_in_source: assert property ((ai & ~$past(pin_in_in)) == 32'h0)
    else $error("function input without pin level");
endmodule // pfsel_props

bind pfsel_top pfsel_props u_props (.clk_sys_in, .rst_b_in, .wb_req_in, .wb_rsp_out,
  .periph_out_in, .periph_oe_in, .periph_in_out, .pin_in_in, .pin_out_out, .pin_oe_out);

// file: tb.sv
`timescale 1ns/10ps
`include "pfsel_map.svh"

module tb;
  logic                         clk_sys_in;
  logic                         rst_b_in;
  pfsel_pkg::pfsel_wb_req_t     wb_req_in;
  pfsel_pkg::pfsel_wb_rsp_t     wb_rsp_out;
  pfsel_pkg::pfsel_func_vec_t   periph_out_in [32];
  pfsel_pkg::pfsel_func_vec_t   periph_oe_in  [32];
  pfsel_pkg::pfsel_func_vec_t   periph_in_out [32];
  logic [31:0]                  pin_in_in;
  logic [31:0]                  pin_out_out;
  logic [31:0]                  pin_oe_out;
  logic [31:0]                  sh [3];
  logic [31:0]                  q;
  pfsel_pkg::pfsel_pin_t [31:0] tbl;
  int                           errors;
  int                           checks_done;

  pfsel_top uut (.clk_sys_in, .rst_b_in, .wb_req_in, .wb_rsp_out, .periph_out_in,
    .periph_oe_in, .periph_in_out, .pin_in_in, .pin_out_out, .pin_oe_out);

  always #5 clk_sys_in = ~clk_sys_in;

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // Waits for ack however long it takes; only the watchdog ends a hung access
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    wb_req_in <= {1'b1, 1'b1, w, a, 4'hf, d};
    do begin
      @(posedge clk_sys_in);
    end while (wb_rsp_out.ack !== 1'b1);
    q = wb_rsp_out.dat;
    wb_req_in <= '0;
    @(posedge clk_sys_in);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    check(q, exp, "read");
  endtask

  // Unlock is spent by the write right behind it, so it is always sent as a pair
  task automatic wsel(input int r, input logic [31:0] d);
    wb(1'b1, `PFSEL_OFS_WMASK, 32'h1);
    wb(1'b1, 8'(4 * r), d);
    sh[r] = d;
  endtask

  function automatic logic [31:0] fill(input int r, input logic [2:0] c);
    logic [31:0] w;
    logic [2:0]  m;
    w = 32'h0;
    for (int p = 0; p < 32; p++) begin
      m = c & (tbl[p].wide ? 3'h7 : 3'h3);
      // Prohibited codes are skipped and leave the field on its first function
      if (tbl[p].reg_idx == r && tbl[p].legal[m]) w = w | (32'(m) << tbl[p].lsb);
    end
    return w;
  endfunction

  task automatic pins;
    logic [2:0]  c;
    logic [31:0] ill, eo, ee;
    logic [7:0]  ei;
    #1;
    for (int p = 0; p < 32; p++) begin
      c = 3'(sh[tbl[p].reg_idx] >> tbl[p].lsb) & (tbl[p].wide ? 3'h7 : 3'h3);
      ill[p] = ~tbl[p].legal[c];
      eo[p] = tbl[p].legal[c] & periph_out_in[p][c];
      ee[p] = tbl[p].legal[c] & periph_oe_in[p][c];
      ei = {7'h0, tbl[p].legal[c] & pin_in_in[p]} << c;
      check({24'h0, periph_in_out[p]}, {24'h0, ei}, "func in");
    end
    check(pin_out_out, eo, "pin out");
    check(pin_oe_out, ee, "pin oe");
    @(posedge clk_sys_in);
    rd(`PFSEL_OFS_ILLEGAL, ill);
  endtask

  task automatic finish_test;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  initial begin
    #200us;
    errors++;
    finish_test;
  end

  initial begin
    clk_sys_in = 1'b0;
    rst_b_in = 1'b0;
    wb_req_in = '0;
    errors = 0;
    checks_done = 0;
    sh = '{default: 32'h0};
    tbl = `PFSEL_PIN_TABLE;
    pin_in_in = 32'hc3a5_0f69;
    for (int p = 0; p < 32; p++) begin
      periph_out_in[p] = 8'h5a ^ 8'(p * 37);
      periph_oe_in[p] = 8'h3c ^ 8'(p * 11);
    end
    repeat (4) @(posedge clk_sys_in);
    rst_b_in <= 1'b1;
    @(posedge clk_sys_in);
    for (int r = 0; r < 3; r++) rd(8'(4 * r), 32'h0);
    pins;
    $display("reset test done");
    wb(1'b1, `PFSEL_OFS_SEL8, 32'h0000_0249);
    rd(`PFSEL_OFS_SEL8, 32'h0);
    rd(`PFSEL_OFS_STATUS, 32'h2);
    wb(1'b1, `PFSEL_OFS_WMASK, 32'h1);
    rd(`PFSEL_OFS_STATUS, 32'h3);
    wb(1'b1, `PFSEL_OFS_SEL9, 32'h8000_0001);
    sh[2] = 32'h8000_0001;
    rd(`PFSEL_OFS_SEL9, sh[2]);
    wb(1'b1, `PFSEL_OFS_SEL9, 32'h0);
    rd(`PFSEL_OFS_SEL9, sh[2]);
    rd(8'h18, 32'h0);
    wb(1'b1, `PFSEL_OFS_STATUS, 32'h2);
    rd(`PFSEL_OFS_STATUS, 32'h0);
    pins;
    $display("unlock test done");
    // Deliberately stores reserved codes in every register to see them isolated
    for (int r = 0; r < 3; r++) begin
      wsel(r, 32'hffff_ffff);
      rd(8'(4 * r), 32'hffff_ffff);
    end
    rd(`PFSEL_OFS_WMASK, 32'h1);
    pins;
    $display("all ones test done");
    for (int c = 0; c < 8; c++) begin
      pin_in_in <= ~pin_in_in;
      for (int r = 0; r < 3; r++) begin
        wsel(r, fill(r, 3'(c)));
        rd(8'(4 * r), sh[r]);
      end
      pins;
    end
    $display("code walk test done");
    finish_test;
  end
endmodule // tb
